// ==== src/dcu_map.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef DCU_MAP_SVH
`define DCU_MAP_SVH
`define DCU_OFF_DATA 12'h000
`define DCU_OFF_IER 12'h004
`define DCU_OFF_IIR 12'h008
`define DCU_OFF_LCR 12'h00c
`define DCU_OFF_MCR 12'h010
`define DCU_OFF_LSR 12'h014
`define DCU_OFF_SCR 12'h01c
`define DCU_OFF_FRAC 12'h020
`define DCU_OFF_CLKM 12'h024
`define DCU_OFF_IRQS 12'h028
`define DCU_OFF_IRQM 12'h02c
`define DCU_OFF_CFG 12'h030
`define DCU_FIFO_DEPTH 64
`define DCU_OS_STD 4'hf
`define DCU_OS_HS 4'hd
`define DCU_LCR_RST 8'h03
`define DCU_DIV_RST 16'h0001
`define DCU_FRAC_RST 8'h10
`define DCU_CLKM_RST 2'h2
`define DCU_IRQM_RST 4'h0
`define DCU_CFG_RST 2'h0
`define DCU_LCR_DLAB 7
`define DCU_LCR_PEN 3
`define DCU_LCR_EPS 4
`define DCU_LCR_STB 2
`define DCU_MCR_LOOP 4
`define DCU_CFG_HS 0
`define DCU_CFG_IR 1
`endif

// ==== src/dcu_pkg.sv ====
// Types shared by the transceiver design
package dcu_pkg;
  typedef enum logic [1:0] {CLK_OFF, CLK_ON, CLK_AUTO} dcu_clkmode_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} dcu_txst_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} dcu_rxst_t;
endpackage

// ==== src/dcu_uart.sv ====
// Dual-class UART transceiver with APB register file
//
// Functional notes
// R1 - Standard class: separate 64-byte receive, transmit FIFOs
// R2 - Standard receive triggers 16, 32, 48, 60
// R3 - Standard transmit triggers 0, 4, 8, 16
// R4 - Classic register offsets, compatible programming model
// R5 - Fractional pre-divider then baud divider
// R6 - Clock modes on, off, auto gated idle
// R7 - Instance 6 adds infrared mode
// R8 - Standard up to 460800 from 13 MHz
// R9 - Standard rates 2400 through 460800 generated
// R10 - Internal loopback returns transmit to receiver
// R11 - High-speed class samples 14 times per bit
// R12 - High-speed up to 921600 from 13 MHz
// R13 - High-speed 64-byte FIFOs, no fractional pre-divider
// R14 - High-speed receive triggers 1,4,8,16,32,48
// R15 - High-speed transmit triggers 0, 4, 8
// R16 - High-speed adds 921600 to standard rates
// R17 - Interrupt on receive or transmit threshold
// R18 - Start, LSB-first data, parity, stop framing
`timescale 1ns/1ps
`include "dcu_map.svh"
module dcu_uart #(
  parameter int INSTANCE = 6
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serialIn,
  output logic serialOut,
  output logic irq
);
  localparam int DW = 6;
  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [7:0] lcr_r;
  logic [7:0] mcr_r;
  logic [7:0] scr_r;
  logic [7:0] ier_r;
  logic [15:0] div_r;
  logic [7:0] frac_r;
  logic [1:0] clkMode_r;
  logic [1:0] cfg_r;
  logic [3:0] irqStat_r;
  logic [3:0] irqMask_r;
  logic [2:0] rxTrigSel_r;
  logic [1:0] txTrigSel_r;
  logic wrEn;
  logic rdEn;
  logic hsMode;
  logic irMode;
  logic loopMode;
  logic [7:0] rxFifo [0:63];
  logic [7:0] txFifo [0:63];
  logic [DW-1:0] rxWp_r, rxRp_r, txWp_r, txRp_r;
  logic [DW:0] rxCnt_r, txCnt_r;
  logic rxPush, rxPop, txPush, txPop;
  logic [7:0] rxByte_r;
  logic rxErr_r;
  logic rxOvr_r;
  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign hsMode = cfg_r[`DCU_CFG_HS];
  assign irMode = (INSTANCE == 6) && !hsMode && cfg_r[`DCU_CFG_IR]; // R7
  assign loopMode = mcr_r[`DCU_MCR_LOOP];
  logic isData;
  assign isData = (paddr == `DCU_OFF_DATA) && !lcr_r[`DCU_LCR_DLAB];
  assign txPush = wrEn && isData && (txCnt_r != 7'(`DCU_FIFO_DEPTH));
  assign rxPop = rdEn && isData && (rxCnt_r != 7'h00);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      lcr_r <= `DCU_LCR_RST;
      mcr_r <= 8'h00;
      scr_r <= 8'h00;
      ier_r <= 8'h00;
      div_r <= `DCU_DIV_RST;
      frac_r <= `DCU_FRAC_RST;
      clkMode_r <= `DCU_CLKM_RST;
      cfg_r <= `DCU_CFG_RST;
      irqMask_r <= `DCU_IRQM_RST;
      rxTrigSel_r <= 3'h0;
      txTrigSel_r <= 2'h0;
    end else if (wrEn) begin // R4
      case (paddr)
        `DCU_OFF_DATA: if (lcr_r[`DCU_LCR_DLAB]) div_r[7:0] <= pwdata[7:0];
        `DCU_OFF_IER: begin
          if (lcr_r[`DCU_LCR_DLAB]) div_r[15:8] <= pwdata[7:0];
          else ier_r <= pwdata[7:0];
        end
        `DCU_OFF_IIR: begin
          rxTrigSel_r <= pwdata[7:5];
          txTrigSel_r <= pwdata[4:3];
        end
        `DCU_OFF_LCR: lcr_r <= pwdata[7:0];
        `DCU_OFF_MCR: mcr_r <= pwdata[7:0];
        `DCU_OFF_SCR: scr_r <= pwdata[7:0];
        `DCU_OFF_FRAC: frac_r <= pwdata[7:0];
        `DCU_OFF_CLKM: clkMode_r <= pwdata[1:0];
        `DCU_OFF_IRQM: irqMask_r <= pwdata[3:0];
        `DCU_OFF_CFG: cfg_r <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // FIFOs
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin // R1 R13
    if (txPush) txFifo[txWp_r] <= pwdata[7:0];
    if (rxPush) rxFifo[rxWp_r] <= rxByte_r;
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      txWp_r <= '0;
      txRp_r <= '0;
      txCnt_r <= '0;
      rxWp_r <= '0;
      rxRp_r <= '0;
      rxCnt_r <= '0;
    end else begin
      if (txPush) txWp_r <= txWp_r + 6'h01;
      if (txPop) txRp_r <= txRp_r + 6'h01;
      txCnt_r <= txCnt_r + 7'(txPush) - 7'(txPop);
      if (rxPush) rxWp_r <= rxWp_r + 6'h01;
      if (rxPop) rxRp_r <= rxRp_r + 6'h01;
      rxCnt_r <= rxCnt_r + 7'(rxPush) - 7'(rxPop);
    end
  end

  // ------------------------------------------------------------
  // Thresholds
  // ------------------------------------------------------------
  logic [6:0] rxTrig, txTrig;
  always_comb begin
    if (hsMode) begin
      case (rxTrigSel_r) // R14
        3'h0: rxTrig = 7'h01;
        3'h1: rxTrig = 7'h04;
        3'h2: rxTrig = 7'h08;
        3'h3: rxTrig = 7'h10;
        3'h4: rxTrig = 7'h20;
        default: rxTrig = 7'h30;
      endcase
      case (txTrigSel_r) // R15
        2'h0: txTrig = 7'h00;
        2'h1: txTrig = 7'h04;
        default: txTrig = 7'h08;
      endcase
    end else begin
      case (rxTrigSel_r[1:0]) // R2
        2'h0: rxTrig = 7'h10;
        2'h1: rxTrig = 7'h20;
        2'h2: rxTrig = 7'h30;
        default: rxTrig = 7'h3c;
      endcase
      case (txTrigSel_r) // R3
        2'h0: txTrig = 7'h00;
        2'h1: txTrig = 7'h04;
        2'h2: txTrig = 7'h08;
        default: txTrig = 7'h10;
      endcase
    end
  end
  logic rxLvl, txLvl, rxLvl_r, txLvl_r;
  assign rxLvl = rxCnt_r >= rxTrig;
  assign txLvl = txCnt_r <= txTrig;

  // ------------------------------------------------------------
  // Clock gating and bit-rate enables
  // ------------------------------------------------------------
  logic busy;
  logic rxBit;
  logic clkRun;
  logic [7:0] fracAcc_r;
  logic preTick;
  logic [15:0] divCnt_r;
  logic sTick;
  logic [8:0] fracSum;
  logic txBusy, rxBusy;
  // Line leaving idle wakes the auto clock so a start bit is not missed
  assign busy = txBusy || rxBusy || (txCnt_r != 7'h00) || !rxBit;
  always_comb begin // R6
    case (clkMode_r)
      dcu_pkg::CLK_OFF: clkRun = 1'b0;
      dcu_pkg::CLK_ON: clkRun = 1'b1;
      default: clkRun = busy;
    endcase
  end
  // Pre-divider passes frac/256 of clock edges; unity when frac is zero
  assign fracSum = {1'b0, fracAcc_r} + {1'b0, frac_r};
  assign preTick = clkRun && (hsMode || frac_r == 8'h00 || fracSum[8]); // R5 R13
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fracAcc_r <= 8'h00;
      divCnt_r <= 16'h0000;
    end else if (clkRun) begin
      if (!hsMode) fracAcc_r <= fracSum[7:0];
      if (preTick) begin // R8 R9 R12 R16
        if (divCnt_r + 16'h0001 >= div_r) divCnt_r <= 16'h0000;
        else divCnt_r <= divCnt_r + 16'h0001;
      end
    end
  end
  assign sTick = preTick && (divCnt_r + 16'h0001 >= div_r);
  logic [3:0] osLast;
  assign osLast = hsMode ? `DCU_OS_HS : `DCU_OS_STD; // R11

  // ------------------------------------------------------------
  // Transmitter
  // ------------------------------------------------------------
  dcu_pkg::dcu_txst_t txSt_r;
  logic [3:0] txOs_r;
  logic [2:0] txBit_r;
  logic [7:0] txSh_r;
  logic txLine_r;
  logic txPar_r;
  logic txStop2_r;
  logic [2:0] dataLast;
  logic irPulse;
  assign dataLast = {1'b1, lcr_r[1:0]};
  assign txBusy = txSt_r != dcu_pkg::TX_IDLE;
  assign txPop = (txSt_r == dcu_pkg::TX_IDLE) && (txCnt_r != 7'h00) && sTick;
  always_ff @(posedge mclk or posedge reset) begin // R18
    if (reset) begin
      txSt_r <= dcu_pkg::TX_IDLE;
      txOs_r <= 4'h0;
      txBit_r <= 3'h0;
      txSh_r <= 8'h00;
      txLine_r <= 1'b1;
      txPar_r <= 1'b0;
      txStop2_r <= 1'b0;
    end else if (txPop) begin
      txSt_r <= dcu_pkg::TX_START;
      txSh_r <= txFifo[txRp_r];
      txPar_r <= !lcr_r[`DCU_LCR_EPS];
      txLine_r <= 1'b0;
      txOs_r <= 4'h0;
      txBit_r <= 3'h0;
      txStop2_r <= lcr_r[`DCU_LCR_STB];
    end else if (sTick && txSt_r != dcu_pkg::TX_IDLE) begin
      txOs_r <= txOs_r + 4'h1;
      if (txOs_r == osLast) begin
        txOs_r <= 4'h0;
        case (txSt_r)
          dcu_pkg::TX_START, dcu_pkg::TX_DATA: begin
            if (txSt_r == dcu_pkg::TX_DATA && txBit_r == dataLast) begin
              txSt_r <= lcr_r[`DCU_LCR_PEN] ? dcu_pkg::TX_PAR : dcu_pkg::TX_STOP;
              txLine_r <= lcr_r[`DCU_LCR_PEN] ? txPar_r : 1'b1;
            end else begin
              if (txSt_r == dcu_pkg::TX_DATA) txBit_r <= txBit_r + 3'h1;
              txSt_r <= dcu_pkg::TX_DATA;
              txLine_r <= txSh_r[0];
              txPar_r <= txPar_r ^ txSh_r[0];
              txSh_r <= {1'b0, txSh_r[7:1]};
            end
          end
          dcu_pkg::TX_PAR: begin
            txSt_r <= dcu_pkg::TX_STOP;
            txLine_r <= 1'b1;
          end
          dcu_pkg::TX_STOP: begin
            if (txStop2_r) txStop2_r <= 1'b0;
            else txSt_r <= dcu_pkg::TX_IDLE;
          end
          default: txSt_r <= dcu_pkg::TX_IDLE;
        endcase
      end
    end
  end
  // Infrared: short high pulse in first quarter of each zero bit
  assign irPulse = !txLine_r && (txOs_r < 4'h4);
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) serialOut <= 1'b1;
    else if (loopMode) serialOut <= irMode ? 1'b0 : 1'b1; // R10
    else serialOut <= irMode ? irPulse : txLine_r; // R7
  end

  // ------------------------------------------------------------
  // Receiver
  // ------------------------------------------------------------
  logic rxS1_r, rxS2_r;
  dcu_pkg::dcu_rxst_t rxSt_r;
  logic [3:0] rxOs_r;
  logic [2:0] rxIdx_r;
  logic [7:0] rxSh_r;
  logic rxPar_r;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rxS1_r <= 1'b1;
      rxS2_r <= 1'b1;
    end else begin
      rxS1_r <= serialIn;
      rxS2_r <= rxS1_r;
    end
  end
  assign rxBit = loopMode ? txLine_r : (irMode ? !rxS2_r : rxS2_r); // R10 R7
  assign rxBusy = rxSt_r != dcu_pkg::RX_IDLE;
  always_ff @(posedge mclk or posedge reset) begin // R18
    if (reset) begin
      rxSt_r <= dcu_pkg::RX_IDLE;
      rxOs_r <= 4'h0;
      rxIdx_r <= 3'h0;
      rxSh_r <= 8'h00;
      rxPar_r <= 1'b0;
      rxByte_r <= 8'h00;
      rxPush <= 1'b0;
      rxErr_r <= 1'b0;
    end else begin
      rxPush <= 1'b0;
      rxErr_r <= 1'b0;
      if (rxSt_r == dcu_pkg::RX_IDLE) begin
        if (!rxBit && sTick) begin
          rxSt_r <= dcu_pkg::RX_START;
          rxOs_r <= 4'h0;
        end
      end else if (sTick) begin
        rxOs_r <= rxOs_r + 4'h1;
        if (rxOs_r == {1'b0, osLast[3:1]}) begin
          case (rxSt_r)
            dcu_pkg::RX_START: begin
              rxSt_r <= rxBit ? dcu_pkg::RX_IDLE : dcu_pkg::RX_DATA;
              rxIdx_r <= 3'h0;
              rxSh_r <= 8'h00;
              rxPar_r <= !lcr_r[`DCU_LCR_EPS];
            end
            dcu_pkg::RX_DATA: begin
              rxSh_r[rxIdx_r] <= rxBit;
              rxPar_r <= rxPar_r ^ rxBit;
              rxIdx_r <= rxIdx_r + 3'h1;
              if (rxIdx_r == dataLast)
                rxSt_r <= lcr_r[`DCU_LCR_PEN] ? dcu_pkg::RX_PAR : dcu_pkg::RX_STOP;
            end
            dcu_pkg::RX_PAR: begin
              rxErr_r <= rxBit != rxPar_r;
              rxSt_r <= dcu_pkg::RX_STOP;
            end
            dcu_pkg::RX_STOP: begin
              rxErr_r <= !rxBit;
              rxByte_r <= rxSh_r;
              rxPush <= rxCnt_r != 7'(`DCU_FIFO_DEPTH);
              rxSt_r <= dcu_pkg::RX_IDLE;
            end
            default: rxSt_r <= dcu_pkg::RX_IDLE;
          endcase
        end
        if (rxOs_r == osLast) rxOs_r <= 4'h0;
      end
    end
  end

  // ------------------------------------------------------------
  // Interrupts: 0 rx level, 1 tx level, 2 line error, 3 overrun
  // ------------------------------------------------------------
  logic [3:0] irqEv;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rxLvl_r <= 1'b0;
      txLvl_r <= 1'b1;
      rxOvr_r <= 1'b0;
    end else begin
      rxLvl_r <= rxLvl;
      txLvl_r <= txLvl;
      rxOvr_r <= (rxSt_r == dcu_pkg::RX_STOP) && sTick && (rxCnt_r == 7'(`DCU_FIFO_DEPTH))
                 && (rxOs_r == {1'b0, osLast[3:1]});
    end
  end
  assign irqEv = {rxOvr_r, rxErr_r, txLvl && !txLvl_r, rxLvl && !rxLvl_r}; // R17
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) irqStat_r <= 4'h0;
    else if (wrEn && paddr == `DCU_OFF_IRQS) irqStat_r <= (irqStat_r & ~pwdata[3:0]) | irqEv;
    else irqStat_r <= irqStat_r | irqEv;
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) irq <= 1'b0;
    else irq <= |(irqStat_r & irqMask_r); // R17
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  logic [31:0] rdVal;
  always_comb begin
    rdVal = 32'h0000_0000;
    case (paddr)
      `DCU_OFF_DATA: rdVal[7:0] = lcr_r[`DCU_LCR_DLAB] ? div_r[7:0] : rxFifo[rxRp_r];
      `DCU_OFF_IER: rdVal[7:0] = lcr_r[`DCU_LCR_DLAB] ? div_r[15:8] : ier_r;
      `DCU_OFF_IIR: rdVal[7:0] = {2'h3, 2'h0, !(|(irqStat_r & irqMask_r)), 3'h0};
      `DCU_OFF_LCR: rdVal[7:0] = lcr_r;
      `DCU_OFF_MCR: rdVal[7:0] = mcr_r;
      `DCU_OFF_LSR: rdVal[7:0] = {1'b0, !txBusy && txCnt_r == 7'h00, txCnt_r == 7'h00,
                                 1'b0, 1'b0, 1'b0, irqStat_r[3], rxCnt_r != 7'h00};
      `DCU_OFF_SCR: rdVal[7:0] = scr_r;
      `DCU_OFF_FRAC: rdVal[7:0] = frac_r;
      `DCU_OFF_CLKM: rdVal[1:0] = clkMode_r;
      `DCU_OFF_IRQS: rdVal[3:0] = irqStat_r;
      `DCU_OFF_IRQM: rdVal[3:0] = irqMask_r;
      `DCU_OFF_CFG: rdVal[1:0] = cfg_r;
      default: rdVal = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) prdata <= rdVal;
  end
endmodule

// ==== test/dcu_uart_assertions.sv ====
// Concurrent checks on the transceiver ports
`timescale 1ns/1ps
`include "dcu_map.svh"
module dcu_uart_assertions (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serialIn,
  input wire logic serialOut,
  input wire logic irq
);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic wrAcc;
  assign wrAcc = psel && penable && pwrite;
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_slverr_low: assert property (!pslverr)
    else $error("pslverr high");
  a_reset_idle: assert property (disable iff (1'b0) reset |-> serialOut && !irq && prdata == 32'h0)
    else $error("outputs not idle in reset");
  a_low_run: assert property ($fell(serialOut) |-> !serialOut [*8])
    else $error("low bit too short");
  a_irq_masked: assert property (wrAcc && paddr == `DCU_OFF_IRQM && pwdata[3:0] == 4'h0
    |=> ##1 !irq [*2])
    else $error("irq high with mask clear");
  a_unmapped_zero: assert property (psel && !penable && !pwrite && paddr >= 12'h034
    |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved");
  a_loop_idle: assert property (wrAcc && paddr == `DCU_OFF_MCR && pwdata[4]
    |=> ##1 serialOut [*8])
    else $error("line active in loopback");
  c_irq: cover property ($rose(irq));
  c_frame: cover property ($fell(serialOut));
  c_rx: cover property ($fell(serialIn));
endmodule

bind dcu_uart dcu_uart_assertions chk (
  .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serialIn(serialIn), .serialOut(serialOut), .irq(irq)
);

// ==== test/dcu_remote.sv ====
// Remote serial transceiver model
`timescale 1ns/1ps
module dcu_remote (
  input wire logic mclk,
  input wire logic txLine,
  output logic rxLine
);
  // ----------------------------------------
  // Framing, send and receive
  // ----------------------------------------
  int bitLen = 16;
  logic parEn = 1'b0;
  logic [9:0] rxq[$];
  logic [7:0] d;
  logic p;
  initial rxLine = 1'b1;
  task sendByte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk);
      rxLine <= f[i];
      repeat (bitLen - 1) @(posedge mclk);
    end
  endtask
  always begin
    @(posedge mclk);
    if (txLine === 1'b0) begin
      repeat (bitLen / 2) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
        repeat (bitLen) @(posedge mclk);
        d[i] = txLine;
      end
      p = 1'b0;
      if (parEn) begin
        repeat (bitLen) @(posedge mclk);
        p = txLine;
      end
      repeat (bitLen) @(posedge mclk);
      rxq.push_back({txLine, p, d});
    end
  end
endmodule

// ==== test/tb_top.sv ====
// Self-checking bench for the transceiver
`timescale 1ns/1ps
`include "dcu_map.svh"
module tb_top;
  logic mclk = 1'b0;
  logic reset = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic serialIn;
  logic serialOut;
  logic irq;
  logic [31:0] rd;
  logic [9:0] expTx[$];
  logic [7:0] expRx[$];
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [11:0] rstAddr [6] = '{`DCU_OFF_LCR, `DCU_OFF_FRAC, `DCU_OFF_CLKM, `DCU_OFF_IRQM,
    `DCU_OFF_CFG, `DCU_OFF_LSR};
  logic [31:0] rstVal [6] = '{32'h3, 32'h10, 32'h2, 32'h0, 32'h0, 32'h60};
  // ----------------------------------------
  // Design, far side, clock
  // ----------------------------------------
  dcu_uart #(.INSTANCE(6)) uut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serialIn(serialIn), .serialOut(serialOut), .irq(irq));
  dcu_remote peer (.mclk(mclk), .txLine(serialOut), .rxLine(serialIn));
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      close_out();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task close_out;
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dat;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(e, rd);
  endtask
  task txByte(input logic [7:0] b, input logic par);
    expTx.push_back({1'b1, par, b});
    apb(1'b1, `DCU_OFF_DATA, {24'h0, b});
  endtask
  task drain;
    int n;
    n = 0;
    while (peer.rxq.size() < expTx.size() && n < 4000) begin
      @(posedge mclk);
      n++;
    end
    chk(32'(expTx.size()), 32'(peer.rxq.size()));
    while (expTx.size() > 0 && peer.rxq.size() > 0) chk(32'(expTx.pop_front()), 32'(peer.rxq.pop_front()));
    expTx.delete();
    peer.rxq.delete();
  endtask
  task waitIrq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    chk(32'h1, {31'h0, irq});
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] b;
    reset <= 1'b1;
    rd = $urandom(32'h2deca31a);
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < 6; i++) rdchk(rstAddr[i], rstVal[i]);
    apb(1'b1, 12'h040, 32'hffffffff);
    rdchk(12'h040, 32'h0);
    apb(1'b1, `DCU_OFF_LCR, 32'h83);
    rdchk(`DCU_OFF_DATA, 32'h1);
    rdchk(`DCU_OFF_IER, 32'h0);
    apb(1'b1, `DCU_OFF_DATA, 32'h1);
    apb(1'b1, `DCU_OFF_LCR, 32'h3);
    apb(1'b1, `DCU_OFF_FRAC, 32'h0);
    for (int i = 0; i < 4; i++) txByte(8'($urandom), 1'b0);
    drain();
    repeat (20) @(posedge mclk);
    apb(1'b0, `DCU_OFF_LSR, 32'h0);
    chk(32'h60, rd & 32'h61);
    apb(1'b1, `DCU_OFF_LCR, 32'h1b);
    peer.parEn = 1'b1;
    b = 8'($urandom);
    txByte(b, ^b);
    drain();
    peer.parEn = 1'b0;
    apb(1'b1, `DCU_OFF_LCR, 32'h3);
    for (int i = 0; i < 3; i++) begin
      b = 8'($urandom);
      peer.sendByte(b);
      apb(1'b0, `DCU_OFF_LSR, 32'h0);
      chk(32'h1, rd & 32'h1);
      rdchk(`DCU_OFF_DATA, {24'h0, b});
    end
    apb(1'b1, `DCU_OFF_CLKM, 32'h0);
    apb(1'b1, `DCU_OFF_DATA, 32'h5a);
    repeat (400) @(posedge mclk);
    chk(32'h0, 32'(peer.rxq.size()));
    apb(1'b1, `DCU_OFF_CLKM, 32'h1);
    repeat (300) @(posedge mclk);
    peer.rxq.delete();
    apb(1'b1, `DCU_OFF_IIR, 32'h0);
    apb(1'b1, `DCU_OFF_IRQS, 32'hf);
    apb(1'b1, `DCU_OFF_IRQM, 32'h2);
    txByte(8'hc3, 1'b0);
    waitIrq();
    apb(1'b0, `DCU_OFF_IRQS, 32'h0);
    chk(32'h2, rd & 32'h2);
    drain();
    apb(1'b1, `DCU_OFF_IRQS, 32'hf);
    apb(1'b1, `DCU_OFF_IRQM, 32'h0);
    txByte(8'h0f, 1'b0);
    drain();
    chk(32'h0, {31'h0, irq});
    apb(1'b0, `DCU_OFF_IRQS, 32'h0);
    chk(32'h2, rd & 32'h2);
    apb(1'b1, `DCU_OFF_CLKM, 32'h0);
    apb(1'b1, `DCU_OFF_IIR, 32'h10);
    apb(1'b1, `DCU_OFF_IRQS, 32'hf);
    apb(1'b1, `DCU_OFF_IRQM, 32'h2);
    for (int i = 0; i < 9; i++) txByte(8'($urandom), 1'b0);
    repeat (20) @(posedge mclk);
    chk(32'h0, {31'h0, irq});
    apb(1'b1, `DCU_OFF_CLKM, 32'h1);
    waitIrq();
    apb(1'b1, `DCU_OFF_IRQM, 32'h0);
    apb(1'b1, `DCU_OFF_IIR, 32'h0);
    drain();
    apb(1'b1, `DCU_OFF_CFG, 32'h1);
    peer.bitLen = 14;
    apb(1'b1, `DCU_OFF_IRQS, 32'hf);
    apb(1'b1, `DCU_OFF_IRQM, 32'h1);
    b = 8'($urandom);
    peer.sendByte(b);
    waitIrq();
    rdchk(`DCU_OFF_DATA, {24'h0, b});
    apb(1'b1, `DCU_OFF_IRQS, 32'h1);
    repeat (3) @(posedge mclk);
    chk(32'h0, {31'h0, irq});
    apb(1'b1, `DCU_OFF_IRQM, 32'h0);
    txByte(8'($urandom), 1'b0);
    drain();
    apb(1'b1, `DCU_OFF_CFG, 32'h0);
    peer.bitLen = 16;
    apb(1'b1, `DCU_OFF_MCR, 32'h10);
    for (int i = 0; i < 2; i++) begin
      b = 8'($urandom);
      expRx.push_back(b);
      apb(1'b1, `DCU_OFF_DATA, {24'h0, b});
    end
    repeat (500) @(posedge mclk);
    while (expRx.size() > 0) rdchk(`DCU_OFF_DATA, {24'h0, expRx.pop_front()});
    chk(32'h0, 32'(peer.rxq.size()));
    apb(1'b1, `DCU_OFF_MCR, 32'h0);
    apb(1'b1, `DCU_OFF_CFG, 32'h2);
    repeat (4) @(posedge mclk);
    chk(32'h0, {31'h0, serialOut});
    close_out();
  end
endmodule
